// file: design/memory_space_address_decode.sv
// Module: memory space address decode and access control, top level
`timescale 1ns/1ps
module memory_space_address_decode (
  input wire clock,
  input wire srst,
  // Program counter control
  input wire pcLoad,
  input wire [22:0] pcLoadValue,
  input wire pcInc,
  input wire pcDec,
  output logic [23:0] pcAddr,
  // Table and remap program access
  input wire mem_decode_pkg::prog_req_t progReq,
  output logic [23:0] progAddrOut,
  output mem_decode_pkg::prog_region_t progRegion,
  output logic progAllowed,
  output logic otpWriteFlag,
  output logic [8:0] writeBlockIdx,
  output logic [6:0] erasePageIdx,
  // Configuration word loading from the memory controller
  output logic cfgReadReq,
  output logic [23:0] cfgReadAddr,
  input wire cfgReadValid,
  input wire [23:0] cfgReadData,
  output logic cfgLoaded,
  output logic [23:0] bootLimitWord,
  output logic [23:0] deviceOptionWord,
  output logic altVectorEnable,
  output logic [23:0] altVectorBase,
  output logic [23:0] generalBase,
  // Program memory word presentation
  input wire [23:0] progFetchData,
  input wire progOddHalf,
  output logic [15:0] progHalfData,
  // Data space read
  input wire mem_decode_pkg::data_req_t rdReq,
  input wire psvEnable,
  input wire [15:0] memRdWord,
  output logic [15:0] rdWordAddr,
  output logic rdWindow,
  output logic [15:0] rdData,
  output logic [15:0] rdNextPtr,
  // Data space write
  input wire mem_decode_pkg::data_req_t wrReq,
  input wire [15:0] wrDataIn,
  output logic [15:0] wrWordAddr,
  output logic [1:0] wrLaneStrobe,
  output logic wrWindow,
  output logic [15:0] wrDataOut,
  output logic [15:0] wrNextPtr,
  // Working register byte load
  input wire wregLoad,
  input wire wregByte,
  input wire [15:0] wregOld,
  input wire [15:0] wregNew,
  output logic [15:0] wregResult,
  // Address error trap
  input wire trapAck,
  output logic addrErrorTrap
);

  // ----------------------------------------------------------------
  // Address generators and program decode
  // ----------------------------------------------------------------
  mem_decode_pkg::data_dec_t rdDec;
  mem_decode_pkg::data_dec_t wrDec;
  mem_decode_pkg::prog_region_t regionW;
  logic [23:0] progAddrW;
  logic [23:0] avtBaseW;
  logic avtEnW;
  logic [23:0] gsBaseW;
  logic [8:0] blkW;
  logic [6:0] pageW;

  // One generator per direction so a read and a write coexist
  data_agu u_rd_agu (
    .req(rdReq),
    .dec(rdDec)
  );

  data_agu u_wr_agu (
    .req(wrReq),
    .dec(wrDec)
  );

  prog_decode u_prog (
    .req(progReq),
    .bootLimit(bootLimitWord[12:0]),
    .altVectorTableDisable(deviceOptionWord[mem_decode_pkg::AVT_DIS_BIT]),
    .progAddr(progAddrW),
    .region(regionW),
    .altVectorBase(avtBaseW),
    .altVectorEnable(avtEnW),
    .generalBase(gsBaseW),
    .writeBlock(blkW),
    .erasePage(pageW)
  );

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic [22:0] pc_q;
  logic [22:0] pc_d;

  // Step of two keeps the counter on the lower word
  always_comb begin
    pc_d = pc_q;
    if (pcLoad) begin
      pc_d = {pcLoadValue[22:1], 1'b0};
    end else if (pcInc) begin
      pc_d = pc_q + 23'd2;
    end else if (pcDec) begin
      pc_d = pc_q - 23'd2;
    end
  end

  // Reset starts at the jump held at address zero
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_q <= 23'(mem_decode_pkg::RESET_JUMP);
    end else if (cfgLoaded) begin
      pc_q <= pc_d;
    end
  end

  assign pcAddr = {1'b0, pc_q};

  // ----------------------------------------------------------------
  // Configuration load sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LD_ISSUE,
    LD_WAIT,
    LD_DONE
  } load_state_t;

  load_state_t ldState_q;
  logic [3:0] cfgIdx_q;
  logic [23:0] bootLimit_q;
  logic [23:0] devOpt_q;
  logic cfgLoaded_q;
  logic cfgReq_q;
  wire lastWord;

  assign lastWord = cfgIdx_q == mem_decode_pkg::CFG_LAST_IDX;

  // Walk every word of the configuration segment while reset ends
  always_ff @(posedge clock) begin
    if (srst) begin
      ldState_q <= LD_ISSUE;
      cfgIdx_q <= 4'h0;
      cfgReq_q <= 1'b0;
      cfgLoaded_q <= 1'b0;
    end else begin
      case (ldState_q)
        LD_ISSUE: begin
          cfgReq_q <= 1'b1;
          ldState_q <= LD_WAIT;
        end
        LD_WAIT: begin
          if (cfgReadValid) begin
            cfgReq_q <= 1'b0;
            cfgIdx_q <= cfgIdx_q + 4'h1;
            ldState_q <= lastWord ? LD_DONE : LD_ISSUE;
            cfgLoaded_q <= lastWord;
          end
        end
        LD_DONE: begin
          cfgLoaded_q <= 1'b1;
        end
        default: begin
          ldState_q <= LD_ISSUE;
        end
      endcase
    end
  end

  // Capture the words the decoder depends on
  always_ff @(posedge clock) begin
    if (srst) begin
      bootLimit_q <= 24'h00_0000;
      devOpt_q <= 24'hFF_FFFF;
    end else if (ldState_q == LD_WAIT && cfgReadValid) begin
      if (cfgIdx_q == mem_decode_pkg::BOOT_LIMIT_IDX) begin
        bootLimit_q <= cfgReadData;
      end
      if (cfgIdx_q == mem_decode_pkg::DEVOPT_IDX) begin
        devOpt_q <= cfgReadData;
      end
    end
  end

  // Word addresses sit at irregular offsets, so use a table
  function automatic logic [23:0] cfgAddrOf(input logic [3:0] idx);
    case (idx)
      4'h0: cfgAddrOf = mem_decode_pkg::SECURITY_CONFIG_WORD;
      4'h1: cfgAddrOf = mem_decode_pkg::BOOT_LIMIT_CONFIG_WORD;
      4'h2: cfgAddrOf = mem_decode_pkg::SIGNATURE_CONFIG_WORD;
      4'h3: cfgAddrOf = mem_decode_pkg::OSCILLATOR_SELECT_WORD;
      4'h4: cfgAddrOf = mem_decode_pkg::OSCILLATOR_CONFIG_WORD;
      4'h5: cfgAddrOf = mem_decode_pkg::WATCHDOG_CONFIG_WORD;
      4'h6: cfgAddrOf = mem_decode_pkg::POWER_ON_CONFIG_WORD;
      4'h7: cfgAddrOf = mem_decode_pkg::DEBUG_CONFIG_WORD;
      default: cfgAddrOf = mem_decode_pkg::DEVICE_OPTION_WORD;
    endcase
  endfunction

  assign cfgReadReq = cfgReq_q;
  assign cfgLoaded = cfgLoaded_q;
  assign bootLimitWord = bootLimit_q;
  assign deviceOptionWord = devOpt_q;

  // ----------------------------------------------------------------
  // Registered program decode outputs
  // ----------------------------------------------------------------
  logic [23:0] cfgAddr_q;
  logic [23:0] progAddr_q;
  mem_decode_pkg::prog_region_t region_q;
  logic allowed_q;
  logic otpWr_q;
  logic [8:0] blk_q;
  logic [6:0] page_q;
  logic [23:0] avtBase_q;
  logic avtEn_q;
  logic [23:0] gsBase_q;
  logic [15:0] progHalf_q;
  wire allowedW;

  assign allowedW = progReq.valid &&
                    regionW != mem_decode_pkg::REG_DENIED;

  // Decode results held one cycle for a clean output
  always_ff @(posedge clock) begin
    if (srst) begin
      cfgAddr_q <= mem_decode_pkg::SECURITY_CONFIG_WORD;
      progAddr_q <= 24'h00_0000;
      region_q <= mem_decode_pkg::REG_VECTOR;
      allowed_q <= 1'b0;
      otpWr_q <= 1'b0;
      blk_q <= 9'h000;
      page_q <= 7'h00;
      avtBase_q <= 24'h00_0000;
      avtEn_q <= 1'b0;
      gsBase_q <= mem_decode_pkg::VECTOR_END;
      progHalf_q <= 16'h0000;
    end else begin
      cfgAddr_q <= cfgAddrOf(cfgIdx_q);
      progAddr_q <= progAddrW;
      region_q <= regionW;
      allowed_q <= allowedW;
      otpWr_q <= allowedW && progReq.write &&
                 regionW == mem_decode_pkg::REG_OTP;
      blk_q <= blkW;
      page_q <= pageW;
      avtBase_q <= avtBaseW;
      avtEn_q <= avtEnW;
      gsBase_q <= gsBaseW;
      // Upper byte of the odd half is unimplemented, reads zero
      progHalf_q <= progOddHalf ? {8'h00, progFetchData[23:16]}
                                : progFetchData[15:0];
    end
  end

  assign cfgReadAddr = cfgAddr_q;
  assign progAddrOut = progAddr_q;
  assign progRegion = region_q;
  assign progAllowed = allowed_q;
  assign otpWriteFlag = otpWr_q;
  assign writeBlockIdx = blk_q;
  assign erasePageIdx = page_q;
  assign altVectorBase = avtBase_q;
  assign altVectorEnable = avtEn_q;
  assign generalBase = gsBase_q;
  assign progHalfData = progHalf_q;

  // ----------------------------------------------------------------
  // Data read and write paths
  // ----------------------------------------------------------------
  wire rdPsvErr;
  wire rdErr;
  wire wrErr;
  wire [15:0] rdByteSel;
  logic [15:0] rdData_q;
  logic [15:0] rdAddr_q;
  logic rdWin_q;
  logic [15:0] rdNext_q;
  logic [15:0] wrAddr_q;
  logic [1:0] wrStrobe_q;
  logic wrWin_q;
  logic [15:0] wrData_q;
  logic [15:0] wrNext_q;
  logic [15:0] wreg_q;

  assign rdPsvErr = rdReq.valid && rdDec.window && !psvEnable;
  assign rdErr = rdDec.misaligned || rdPsvErr;
  assign wrErr = wrDec.misaligned;
  // Byte picked by the address LSB lands on the low lane
  assign rdByteSel = rdReq.addr[0] ? {8'h00, memRdWord[15:8]}
                                   : {8'h00, memRdWord[7:0]};

  always_ff @(posedge clock) begin
    if (srst) begin
      rdData_q <= 16'h0000;
      rdAddr_q <= 16'h0000;
      rdWin_q <= 1'b0;
      rdNext_q <= 16'h0000;
    end else begin
      rdData_q <= rdReq.byteOp ? rdByteSel : memRdWord;
      rdAddr_q <= rdDec.wordAddr;
      rdWin_q <= rdReq.valid && rdDec.window;
      rdNext_q <= rdDec.nextPtr;
    end
  end

  // Misaligned word write executes but never strobes memory
  always_ff @(posedge clock) begin
    if (srst) begin
      wrAddr_q <= 16'h0000;
      wrStrobe_q <= 2'b00;
      wrWin_q <= 1'b0;
      wrData_q <= 16'h0000;
      wrNext_q <= 16'h0000;
    end else begin
      wrAddr_q <= wrDec.wordAddr;
      wrStrobe_q <= (wrReq.valid && !wrErr) ? wrDec.laneEn
                                            : 2'b00;
      wrWin_q <= wrReq.valid && wrDec.window;
      // Byte data replicated so either lane carries it
      wrData_q <= wrReq.byteOp ? {wrDataIn[7:0], wrDataIn[7:0]}
                               : wrDataIn;
      wrNext_q <= wrDec.nextPtr;
    end
  end

  // Byte loads merge into the low byte only
  always_ff @(posedge clock) begin
    if (srst) begin
      wreg_q <= 16'h0000;
    end else if (wregLoad) begin
      wreg_q <= wregByte ? {wregOld[15:8], wregNew[7:0]}
                         : wregNew;
    end
  end

  assign rdData = rdData_q;
  assign rdWordAddr = rdAddr_q;
  assign rdWindow = rdWin_q;
  assign rdNextPtr = rdNext_q;
  assign wrWordAddr = wrAddr_q;
  assign wrLaneStrobe = wrStrobe_q;
  assign wrWindow = wrWin_q;
  assign wrDataOut = wrData_q;
  assign wrNextPtr = wrNext_q;
  assign wregResult = wreg_q;

  // ----------------------------------------------------------------
  // Address error trap
  // ----------------------------------------------------------------
  logic trap_q;

  // New error wins over an acknowledge in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      trap_q <= 1'b0;
    end else if (rdErr || wrErr) begin
      trap_q <= 1'b1;
    end else if (trapAck) begin
      trap_q <= 1'b0;
    end
  end

  assign addrErrorTrap = trap_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pc_step;
    @(posedge clock) disable iff (srst)
      cfgLoaded && !pcLoad && pcInc |=>
        pcAddr[22:0] == $past(pcAddr[22:0]) + 23'd2;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter did not step by two");

  property p_denied;
    @(posedge clock) disable iff (srst)
      progReq.valid && !progReq.tblOp && progReq.page[7] |=> !progAllowed;
  endproperty
  a_denied: assert property (p_denied)
    else $error("upper program half reached without table escape");

  property p_misaligned_write;
    @(posedge clock) disable iff (srst)
      wrReq.valid && !wrReq.byteOp && wrReq.addr[0]
      |=> wrLaneStrobe == 2'b00 && addrErrorTrap;
  endproperty
  a_misaligned_write: assert property (p_misaligned_write)
    else $error("misaligned word write not suppressed");

  property p_byte_strobe;
    @(posedge clock) disable iff (srst)
      wrReq.valid && wrReq.byteOp
      |=> wrLaneStrobe == ($past(wrReq.addr[0]) ? 2'b10 : 2'b01);
  endproperty
  a_byte_strobe: assert property (p_byte_strobe)
    else $error("byte write strobed the wrong lane");

  property p_psv_trap;
    @(posedge clock) disable iff (srst)
      rdReq.valid && rdReq.addr[15] && !psvEnable |=> addrErrorTrap;
  endproperty
  a_psv_trap: assert property (p_psv_trap)
    else $error("window read without visibility did not trap");

  property p_trap_hold;
    @(posedge clock) disable iff (srst)
      addrErrorTrap && !trapAck |=> addrErrorTrap;
  endproperty
  a_trap_hold: assert property (p_trap_hold)
    else $error("trap request dropped before acknowledge");

  property p_post_inc;
    @(posedge clock) disable iff (srst)
      rdReq.postInc |=> rdNextPtr ==
        $past(rdReq.addr) + ($past(rdReq.byteOp) ? 16'h0001 : 16'h0002);
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("post increment step wrong");

  property p_wreg_byte;
    @(posedge clock) disable iff (srst)
      wregLoad && wregByte |=> wregResult[15:8] == $past(wregOld[15:8]);
  endproperty
  a_wreg_byte: assert property (p_wreg_byte)
    else $error("byte load changed the high byte");

  property p_cfg_load;
    @(posedge clock) disable iff (srst)
      $rose(cfgLoaded) |-> $past(cfgReadAddr) ==
        mem_decode_pkg::DEVICE_OPTION_WORD;
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("load finished before the last configuration word");

endmodule

// file: shared/mem_decode_pkg.sv
// Package: constants and types for the memory space address decode block
package mem_decode_pkg;

  // ----------------------------------------------------------------
  // Program space map
  // ----------------------------------------------------------------
  localparam logic [23:0] USER_TOP = 24'h7F_FFFF;
  localparam logic [23:0] VECTOR_END = 24'h00_0200;
  localparam logic [23:0] RESET_JUMP = 24'h00_0000;
  localparam logic [23:0] RESET_TARGET = 24'h00_0002;
  localparam logic [23:0] IVT_FIRST = 24'h00_0004;
  localparam logic [23:0] IVT_LAST = 24'h00_00FF;
  localparam logic [23:0] AVT_SCALE = 24'h00_0800;
  localparam logic [23:0] OTP_FIRST = 24'h80_1700;
  localparam logic [23:0] OTP_LAST = 24'h80_17FE;
  localparam int OTP_BYTES = 256;
  localparam int WRITE_BLOCK_WORDS = 128;
  localparam int ERASE_PAGE_WORDS = 1024;
  localparam int PAGE_ADDR_SHIFT = 11;
  localparam int ROW_ADDR_SHIFT = 8;
  localparam int TBL_PAGE_ESC_BIT = 7;

  // ----------------------------------------------------------------
  // Configuration words (program addresses)
  // ----------------------------------------------------------------
  localparam logic [23:0] CFG_BASE = 24'h02_AF00;
  localparam logic [23:0] SECURITY_CONFIG_WORD = 24'h02_AF00;
  localparam logic [23:0] BOOT_LIMIT_CONFIG_WORD = 24'h02_AF10;
  localparam logic [23:0] SIGNATURE_CONFIG_WORD = 24'h02_AF14;
  localparam logic [23:0] OSCILLATOR_SELECT_WORD = 24'h02_AF18;
  localparam logic [23:0] OSCILLATOR_CONFIG_WORD = 24'h02_AF1C;
  localparam logic [23:0] WATCHDOG_CONFIG_WORD = 24'h02_AF20;
  localparam logic [23:0] POWER_ON_CONFIG_WORD = 24'h02_AF24;
  localparam logic [23:0] DEBUG_CONFIG_WORD = 24'h02_AF28;
  localparam logic [23:0] DEVICE_OPTION_WORD = 24'h02_AF2C;
  localparam int CFG_WORDS = 9;
  localparam logic [3:0] CFG_LAST_IDX = 4'h8;
  localparam logic [3:0] BOOT_LIMIT_IDX = 4'h1;
  localparam logic [3:0] DEVOPT_IDX = 4'h8;
  localparam int AVT_DIS_BIT = 3;

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [15:0] DS_WINDOW_BASE = 16'h8000;
  localparam logic [15:0] DS_ONCHIP_TOP = 16'h7FFF;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Program space access request from the core
  typedef struct packed {
    logic valid;
    logic tblOp;
    logic write;
    logic [7:0] page;
    logic [15:0] offset;
  } prog_req_t;

  // Data space access request (read or write generator)
  typedef struct packed {
    logic valid;
    logic byteOp;
    logic postInc;
    logic [15:0] addr;
  } data_req_t;

  // Decoded data access
  typedef struct packed {
    logic [15:0] wordAddr;
    logic [1:0] laneEn;
    logic window;
    logic misaligned;
    logic [15:0] nextPtr;
  } data_dec_t;

  // Region of a program address
  typedef enum logic [2:0] {
    REG_VECTOR,
    REG_BOOT,
    REG_GENERAL,
    REG_CONFIG,
    REG_OTP,
    REG_DENIED
  } prog_region_t;

endpackage

// file: design/data_agu.sv
// Module: one data space address generator (read or write)
`timescale 1ns/1ps
module data_agu (
  input wire mem_decode_pkg::data_req_t req,
  output mem_decode_pkg::data_dec_t dec
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [15:0] stepVal;
  wire oddAddr;

  // Byte addressed: even byte is the low lane, odd the high lane
  assign oddAddr = req.addr[0];
  assign dec.wordAddr = {req.addr[15:1], 1'b0};
  assign dec.laneEn = req.byteOp ? (oddAddr ? 2'b10 : 2'b01)
                                 : 2'b11;
  assign dec.window = req.addr >= mem_decode_pkg::DS_WINDOW_BASE;
  assign dec.misaligned = req.valid && !req.byteOp && oddAddr;
  // Post increment steps one byte or one word
  assign stepVal = req.byteOp ? 16'h0001 : 16'h0002;
  assign dec.nextPtr = req.postInc ? req.addr + stepVal : req.addr;

endmodule

// file: design/prog_decode.sv
// Module: program space address decode and segment layout
`timescale 1ns/1ps
module prog_decode (
  input wire mem_decode_pkg::prog_req_t req,
  input wire [12:0] bootLimit,
  input wire altVectorTableDisable,
  output logic [23:0] progAddr,
  output mem_decode_pkg::prog_region_t region,
  output logic [23:0] altVectorBase,
  output logic altVectorEnable,
  output logic [23:0] generalBase,
  output logic [8:0] writeBlock,
  output logic [6:0] erasePage
);

  // ----------------------------------------------------------------
  // Address forming and segment sizes
  // ----------------------------------------------------------------
  wire escape;
  wire [23:0] bootEnd;
  wire bootPresent;
  wire [23:0] vecFromAddr;

  // Table ops with page bit 7 may leave user space
  assign escape = req.tblOp && req.page[mem_decode_pkg::TBL_PAGE_ESC_BIT];
  assign progAddr = {req.page, req.offset};
  assign bootPresent = bootLimit > 13'd1;
  assign bootEnd = 24'(bootLimit) << mem_decode_pkg::PAGE_ADDR_SHIFT;
  // Alternate table only with a boot segment of three pages or more
  assign altVectorEnable = bootLimit >= 13'd3 && !altVectorTableDisable;
  assign altVectorBase = 24'(bootLimit - 13'd1) * mem_decode_pkg::AVT_SCALE;
  assign generalBase = bootPresent ? bootEnd + (altVectorEnable ?
    mem_decode_pkg::AVT_SCALE : 24'h00_0000) : mem_decode_pkg::VECTOR_END;
  assign vecFromAddr = progAddr;
  assign writeBlock = 9'(progAddr >> mem_decode_pkg::ROW_ADDR_SHIFT);
  assign erasePage = 7'(progAddr >> mem_decode_pkg::PAGE_ADDR_SHIFT);

  // Region classification
  always_comb begin
    if (progAddr > mem_decode_pkg::USER_TOP && !escape) begin
      region = mem_decode_pkg::REG_DENIED;
    end else if (progAddr >= mem_decode_pkg::OTP_FIRST &&
                 progAddr <= mem_decode_pkg::OTP_LAST) begin
      region = mem_decode_pkg::REG_OTP;
    end else if (progAddr > mem_decode_pkg::USER_TOP) begin
      region = mem_decode_pkg::REG_CONFIG;
    end else if (vecFromAddr < mem_decode_pkg::VECTOR_END) begin
      region = mem_decode_pkg::REG_VECTOR;
    end else if (progAddr >= mem_decode_pkg::CFG_BASE) begin
      region = mem_decode_pkg::REG_CONFIG;
    end else if (bootPresent && progAddr < generalBase) begin
      region = mem_decode_pkg::REG_BOOT;
    end else begin
      region = mem_decode_pkg::REG_GENERAL;
    end
  end

endmodule

// file: dv/cfg_word_server.sv
// Partner model: controller that serves configuration words at reset
`timescale 1ns/1ps
module cfg_word_server (
  input wire clock,
  input wire srst,
  input wire cfgReadReq,
  input wire [23:0] cfgReadAddr,
  output logic cfgReadValid,
  output logic [23:0] cfgReadData
);
  // One word per request; the data bus toggles outside the valid pulse
  always_ff @(posedge clock) begin
    if (srst) begin
      cfgReadValid <= 1'b0;
      cfgReadData <= 24'h00_A5A5;
    end else if (!cfgReadReq || cfgReadValid) begin
      cfgReadValid <= 1'b0;
      cfgReadData <= ~cfgReadData;
    end else begin
      cfgReadValid <= 1'b1;
      // Limit 3 with the disable bit clear enables the alternate table
      cfgReadData <=
        (cfgReadAddr == mem_decode_pkg::BOOT_LIMIT_CONFIG_WORD) ?
        24'h00_0003 :
        (cfgReadAddr == mem_decode_pkg::DEVICE_OPTION_WORD) ?
        24'hFF_FFF7 : cfgReadAddr;
    end
  end
endmodule

// file: dv/testbench.sv
// Testbench: directed scenarios for the memory space decode block
`timescale 1ns/1ps
module testbench;
  logic clock = 0, srst = 1, pcLoad = 0, pcInc = 0, pcDec = 0;
  logic [22:0] pcLoadValue = 0;
  mem_decode_pkg::prog_req_t progReq = '0;
  mem_decode_pkg::data_req_t rdReq = '0, wrReq = '0;
  logic cfgReadReq, cfgReadValid, cfgLoaded, altVectorEnable;
  logic [23:0] pcAddr, cfgReadAddr, cfgReadData, altVectorBase, generalBase;
  logic progOddHalf = 0, psvEnable = 0, wregLoad = 0, wregByte = 0;
  logic trapAck = 0, progAllowed, otpWriteFlag, addrErrorTrap;
  logic [23:0] progFetchData = 0;
  logic [15:0] memRdWord = 0, wrDataIn = 0, wregOld = 0, wregNew = 0;
  logic [15:0] progHalfData, rdData, rdNextPtr, wregResult;
  logic [1:0] wrLaneStrobe;
  logic rdWindow, wrWindow;
  logic [15:0] rdWordAddr, wrWordAddr, wrDataOut, wrNextPtr;
  logic [23:0] progAddrOut, bootLimitWord, deviceOptionWord;
  logic [8:0] writeBlockIdx;
  logic [6:0] erasePageIdx;
  mem_decode_pkg::prog_region_t progRegion;
  int n_fail = 0, checks = 0;

  // ----------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------
  memory_space_address_decode dut_u (.clock(clock), .srst(srst),
    .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .pcInc(pcInc),
    .pcDec(pcDec), .pcAddr(pcAddr), .progReq(progReq),
    .progAddrOut(progAddrOut), .progRegion(progRegion),
    .progAllowed(progAllowed), .otpWriteFlag(otpWriteFlag),
    .writeBlockIdx(writeBlockIdx), .erasePageIdx(erasePageIdx),
    .cfgReadReq(cfgReadReq), .cfgReadAddr(cfgReadAddr),
    .cfgReadValid(cfgReadValid), .cfgReadData(cfgReadData),
    .cfgLoaded(cfgLoaded), .bootLimitWord(bootLimitWord),
    .deviceOptionWord(deviceOptionWord), .altVectorEnable(altVectorEnable),
    .altVectorBase(altVectorBase), .generalBase(generalBase),
    .progFetchData(progFetchData), .progOddHalf(progOddHalf),
    .progHalfData(progHalfData), .rdReq(rdReq), .psvEnable(psvEnable),
    .memRdWord(memRdWord), .rdWordAddr(rdWordAddr), .rdWindow(rdWindow),
    .rdData(rdData), .rdNextPtr(rdNextPtr), .wrReq(wrReq),
    .wrDataIn(wrDataIn), .wrWordAddr(wrWordAddr),
    .wrLaneStrobe(wrLaneStrobe), .wrWindow(wrWindow),
    .wrDataOut(wrDataOut), .wrNextPtr(wrNextPtr), .wregLoad(wregLoad),
    .wregByte(wregByte), .wregOld(wregOld), .wregNew(wregNew),
    .wregResult(wregResult), .trapAck(trapAck),
    .addrErrorTrap(addrErrorTrap));
  cfg_word_server partner_u (.clock(clock), .srst(srst),
    .cfgReadReq(cfgReadReq), .cfgReadAddr(cfgReadAddr),
    .cfgReadValid(cfgReadValid), .cfgReadData(cfgReadData));
  initial begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs answer one edge after the request edge
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cfg;
    int i;
    step();
    chk(pcAddr, 24'h00_0000);
    for (i = 0; i < 200 && cfgLoaded !== 1'b1; i++) step();
    // Decoded layout follows the captured words one edge later
    step();
    chk(cfgLoaded, 1);
    chk(bootLimitWord, 24'h00_0003);
    chk(deviceOptionWord, 24'hFF_FFF7);
    chk(altVectorEnable, 1);
    chk(altVectorBase, 24'h00_1000);
    chk(generalBase, 24'h00_2000);
    $display("test cfg done");
  endtask
  task automatic t_pc;
    @(posedge clock) begin
      pcLoad <= 1;
      pcLoadValue <= 23'h00_0101;
    end
    @(posedge clock) begin
      pcLoad <= 0;
      pcInc <= 1;
    end
    #1 chk(pcAddr, 24'h00_0100);
    @(posedge clock) begin
      pcInc <= 0;
      pcDec <= 1;
    end
    #1 chk(pcAddr, 24'h00_0102);
    @(posedge clock) pcDec <= 0;
    #1 chk(pcAddr, 24'h00_0100);
    $display("test pc done");
  endtask
  task automatic t_prog;
    @(posedge clock) begin
      progReq <= '{1'b1, 1'b1, 1'b1, 8'h80, 16'h1700};
      progFetchData <= 24'h12_3456;
      progOddHalf <= 1;
    end
    @(posedge clock) progReq <= '{1'b1, 1'b0, 1'b0, 8'h80, 16'h1700};
    #1 chk(progAllowed, 1);
    chk(otpWriteFlag, 1);
    chk(progHalfData, 16'h0012);
    chk(progRegion, mem_decode_pkg::REG_OTP);
    chk(progAddrOut, 24'h80_1700);
    chk(writeBlockIdx, 9'h017);
    chk(erasePageIdx, 7'h02);
    @(posedge clock) progReq <= '0;
    #1 chk(progAllowed, 0);
    chk(progRegion, mem_decode_pkg::REG_DENIED);
    $display("test prog done");
  endtask
  task automatic t_data;
    @(posedge clock) begin
      rdReq <= '{1'b1, 1'b1, 1'b1, 16'h0005};
      memRdWord <= 16'hABCD;
      wrReq <= '{1'b1, 1'b1, 1'b0, 16'h0003};
      wregLoad <= 1;
      wregByte <= 1;
      wregOld <= 16'h1234;
      wregNew <= 16'h00EF;
    end
    @(posedge clock) begin
      rdReq <= '0;
      wrReq <= '{1'b1, 1'b0, 1'b0, 16'h0003};
      wregLoad <= 0;
    end
    #1 chk(rdData, 16'h00AB);
    chk(rdNextPtr, 16'h0006);
    chk(wrLaneStrobe, 2'b10);
    chk(wregResult, 16'h12EF);
    @(posedge clock) begin
      wrReq <= '0;
      trapAck <= 1;
    end
    #1 chk(wrLaneStrobe, 2'b00);
    chk(addrErrorTrap, 1);
    @(posedge clock) trapAck <= 0;
    #1 chk(addrErrorTrap, 0);
    $display("test data done");
  endtask
  task automatic t_win;
    @(posedge clock) begin
      rdReq <= '{1'b1, 1'b0, 1'b0, 16'h8002};
      wrReq <= '{1'b1, 1'b1, 1'b1, 16'h8001};
      wrDataIn <= 16'h00C3;
    end
    @(posedge clock) begin
      rdReq <= '{1'b1, 1'b0, 1'b0, 16'h0001};
      wrReq <= '0;
      trapAck <= 1;
    end
    #1 chk(addrErrorTrap, 1);
    chk(rdWindow, 1);
    chk(rdWordAddr, 16'h8002);
    chk(wrWindow, 1);
    chk(wrWordAddr, 16'h8000);
    chk(wrLaneStrobe, 2'b10);
    chk(wrDataOut, 16'hC3C3);
    chk(wrNextPtr, 16'h8002);
    // Misaligned read error must win over the pending acknowledge
    @(posedge clock) begin
      rdReq <= '{1'b1, 1'b0, 1'b0, 16'h8000};
      psvEnable <= 1;
    end
    #1 chk(addrErrorTrap, 1);
    chk(rdData, 16'hABCD);
    chk(rdWindow, 0);
    @(posedge clock) begin
      rdReq <= '0;
      trapAck <= 0;
      psvEnable <= 0;
    end
    #1 chk(addrErrorTrap, 0);
    chk(rdWindow, 1);
    $display("test win done");
  endtask

  // Watchdog sized well beyond the directed sequence
  initial begin
    #20000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clock);
    srst <= 0;
    t_cfg();
    t_pc();
    t_prog();
    t_data();
    t_win();
    tally_and_finish();
  end
endmodule
